// ==== core/ccv_cfg.svh ====
`ifndef CCV_CFG_SVH
`define CCV_CFG_SVH

// register byte offsets inside the block window
`define CCV_OFS_CH0        8'h34
`define CCV_OFS_CH1        8'h38
`define CCV_OFS_CH2        8'h3C
`define CCV_OFS_CFG        8'hFC
`define CCV_OFS_CTRL       8'h50
`define CCV_OFS_STATUS     8'h54
`define CCV_OFS_MASK       8'h58

// field positions
`define CCV_CFG_SUPPRESS   1
`define CCV_CTRL_INMODE    0
`define CCV_CTRL_ENABLE    4
`define CCV_CTRL_SHADOW    8
`define CCV_ST_CAPTURE     0
`define CCV_ST_COMPARE     4

// reset values
`define CCV_RST_WORD       32'h0000_0000
`define CCV_RST_VALUE      16'h0000
`define CCV_RST_CFG        1'h0
`define CCV_RST_CHAN3      3'h0

// only whole-word writes are honoured
`define CCV_HSIZE_WORD     3'h2

`endif

// ==== core/ccv_pkg.sv ====
`default_nettype none

package ccv_pkg;

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
    } ccv_wr_t;

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
    } ccv_rd_t;

    typedef struct packed {
        logic in_mode;
        logic enable;
        logic shadow_en;
    } ccv_chan_cfg_t;

endpackage : ccv_pkg

`default_nettype wire

// ==== core/ccv_ahb.sv ====
`include "ccv_cfg.svh"
`default_nettype none

module ccv_ahb (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    input  wire logic [31:0]        rdata,
    output var  ccv_pkg::ccv_wr_t   wr,
    output var  ccv_pkg::ccv_rd_t   rd,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp
);
    import ccv_pkg::*;

    logic       wph_r;
    logic       wok_r;
    logic [7:0] waddr_r;
    logic       rph_r;
    logic [7:0] raddr_r;
    logic       rdy_r;
    logic [31:0] rdata_r;

    wire logic take = hsel & hready & htrans[1];

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_r   <= 1'b0;
            wok_r   <= 1'b0;
            waddr_r <= 8'h00;
            rph_r   <= 1'b0;
            raddr_r <= 8'h00;
            rdy_r   <= 1'b1;
            rdata_r <= `CCV_RST_WORD;
        end else begin
            wph_r <= take & hwrite;
            rph_r <= take & ~hwrite;
            if (take) begin
                waddr_r <= haddr[7:0];
                raddr_r <= haddr[7:0];
                wok_r   <= (hsize == `CCV_HSIZE_WORD);
            end
            if (take & ~hwrite) begin
                rdy_r <= 1'b0;
            end
            if (rph_r) begin
                rdata_r <= rdata;
                rdy_r   <= 1'b1;
            end
        end
    end

    assign wr.en     = wph_r & wok_r;
    assign wr.addr   = waddr_r;
    assign wr.data   = hwdata;
    assign rd.en     = rph_r;
    assign rd.addr   = raddr_r;
    assign hreadyout = rdy_r;
    assign hrdata    = rdata_r;
    assign hresp     = 1'b0;

endmodule : ccv_ahb

`default_nettype wire

// ==== core/ccv_chan.sv ====
`include "ccv_cfg.svh"
`default_nettype none

module ccv_chan (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire ccv_pkg::ccv_chan_cfg_t cfg,
    input  wire logic                 wr_en,
    input  wire logic [15:0]          wr_data,
    input  wire logic                 capture,
    input  wire logic                 update,
    input  wire logic [15:0]          count,
    output logic [15:0]               value,
    output logic                      captured,
    output logic                      hit
);
    import ccv_pkg::*;

    logic [15:0] value_r;
    logic [15:0] value_nxt;
    logic [15:0] active_r;
    logic [15:0] active_nxt;

    wire logic        cap_ok  = cfg.in_mode & cfg.enable & capture;
    wire logic        load_ok = ~cfg.in_mode & wr_en;
    wire logic [15:0] cmp_ref = cfg.shadow_en ? active_r : value_r;

    assign captured  = cap_ok;
    // software writes never reach the field in input mode
    assign value_nxt = cap_ok  ? count :
                       load_ok ? wr_data :
                       value_r;
    // with shadowing on, the shadow copy moves only on update events
    assign active_nxt = (~cfg.shadow_en | update) ? value_r : active_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_r  <= `CCV_RST_VALUE;
            active_r <= `CCV_RST_VALUE;
        end else begin
            value_r  <= value_nxt;
            active_r <= active_nxt;
        end
    end

    assign value = value_r;
    assign hit   = ~cfg.in_mode & (count == cmp_ref);

endmodule : ccv_chan

`default_nettype wire

// ==== core/ccv_top.sv ====
// Notes on behaviour
// - in input mode a channel's value field takes the counter at its last capture.
// - in input mode software writes leave the captured value untouched.
// - in output mode the written value is the reference compared with the counter.
// - with shadowing on, the active compare copy is loaded only at update events.
// - with suppression set, a write equal to the held value is discarded.
// - software sets and clears the suppression bit, held at bit 1 of config.
// - reset clears the config register at 0xFC, so suppression starts off.
// - an input channel captures only while its enable bit is set.
`include "ccv_cfg.svh"
`default_nettype none

module ccv_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    input  wire logic [15:0] count,
    input  wire logic [2:0]  capture,
    input  wire logic        update,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic [2:0]       compare_evt,
    output logic             irq
);
    import ccv_pkg::*;

    ccv_wr_t       wr;
    ccv_rd_t       rd;
    logic [31:0]   rdata;

    ccv_ahb u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rdata     (rdata),
        .wr        (wr),
        .rd        (rd),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp)
    );

    // control and configuration state
    logic          suppress_r;
    logic          suppress_nxt;
    logic [2:0]    in_mode_r;
    logic [2:0]    in_mode_nxt;
    logic [2:0]    enable_r;
    logic [2:0]    enable_nxt;
    logic [2:0]    shadow_r;
    logic [2:0]    shadow_nxt;
    logic [2:0]    cap_st_r;
    logic [2:0]    cap_st_nxt;
    logic [2:0]    cmp_st_r;
    logic [2:0]    cmp_st_nxt;
    logic [2:0]    cap_mask_r;
    logic [2:0]    cap_mask_nxt;
    logic [2:0]    cmp_mask_r;
    logic [2:0]    cmp_mask_nxt;
    logic [2:0]    hit_prev_r;
    logic [2:0]    cmp_evt_r;
    logic          irq_r;

    // address decode
    wire logic     wr_cfg    = wr.en & (wr.addr == `CCV_OFS_CFG);
    wire logic     wr_ctrl   = wr.en & (wr.addr == `CCV_OFS_CTRL);
    wire logic     wr_mask   = wr.en & (wr.addr == `CCV_OFS_MASK);
    wire logic     rd_status = rd.en & (rd.addr == `CCV_OFS_STATUS);

    logic [7:0]    chan_ofs  [3];
    assign chan_ofs[0] = `CCV_OFS_CH0;
    assign chan_ofs[1] = `CCV_OFS_CH1;
    assign chan_ofs[2] = `CCV_OFS_CH2;

    logic [15:0]   value     [3];
    logic [2:0]    wr_chan;
    logic [2:0]    captured;
    logic [2:0]    hit;
    logic [2:0]    hit_rise;
    logic [31:0]   chan_word [3];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
            ccv_chan_cfg_t cfg;
            wire logic     addr_hit;
            wire logic     same;

            assign cfg.in_mode   = in_mode_r[gi];
            assign cfg.enable    = enable_r[gi];
            assign cfg.shadow_en = shadow_r[gi];

            // reserved upper bits read as zero
            assign chan_word[gi] = {16'h0000, value[gi]};
            assign addr_hit      = wr.en & (wr.addr == chan_ofs[gi]);
            // whole word compared, so a stray upper bit still lands
            assign same          = (wr.data == chan_word[gi]);
            assign wr_chan[gi]   = addr_hit & ~(suppress_r & same);

            ccv_chan u_chan (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .cfg      (cfg),
                .wr_en    (wr_chan[gi]),
                .wr_data  (wr.data[15:0]),
                .capture  (capture[gi]),
                .update   (update),
                .count    (count),
                .value    (value[gi]),
                .captured (captured[gi]),
                .hit      (hit[gi])
            );
        end
    endgenerate

    // a counter parked on the reference raises one event, not one per cycle
    assign hit_rise = hit & ~hit_prev_r;

    // next-state for software-owned bits
    assign suppress_nxt = wr_cfg ? wr.data[`CCV_CFG_SUPPRESS]
                                 : suppress_r;
    assign in_mode_nxt  = wr_ctrl ? wr.data[`CCV_CTRL_INMODE +: 3]
                                  : in_mode_r;
    assign enable_nxt   = wr_ctrl ? wr.data[`CCV_CTRL_ENABLE +: 3]
                                  : enable_r;
    assign shadow_nxt   = wr_ctrl ? wr.data[`CCV_CTRL_SHADOW +: 3]
                                  : shadow_r;
    assign cap_mask_nxt = wr_mask ? wr.data[`CCV_ST_CAPTURE +: 3]
                                  : cap_mask_r;
    assign cmp_mask_nxt = wr_mask ? wr.data[`CCV_ST_COMPARE +: 3]
                                  : cmp_mask_r;

    // sticky status: a new event in the clearing read survives it
    assign cap_st_nxt = (cap_st_r & ~{3{rd_status}}) | captured;
    assign cmp_st_nxt = (cmp_st_r & ~{3{rd_status}}) | hit_rise;

    wire logic irq_nxt = |(cap_st_nxt & cap_mask_nxt)
                       | |(cmp_st_nxt & cmp_mask_nxt);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            suppress_r <= `CCV_RST_CFG;
            in_mode_r  <= `CCV_RST_CHAN3;
            enable_r   <= `CCV_RST_CHAN3;
            shadow_r   <= `CCV_RST_CHAN3;
            cap_mask_r <= `CCV_RST_CHAN3;
            cmp_mask_r <= `CCV_RST_CHAN3;
        end else begin
            suppress_r <= suppress_nxt;
            in_mode_r  <= in_mode_nxt;
            enable_r   <= enable_nxt;
            shadow_r   <= shadow_nxt;
            cap_mask_r <= cap_mask_nxt;
            cmp_mask_r <= cmp_mask_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_st_r   <= `CCV_RST_CHAN3;
            cmp_st_r   <= `CCV_RST_CHAN3;
            hit_prev_r <= `CCV_RST_CHAN3;
            cmp_evt_r  <= `CCV_RST_CHAN3;
            irq_r      <= 1'b0;
        end else begin
            cap_st_r   <= cap_st_nxt;
            cmp_st_r   <= cmp_st_nxt;
            hit_prev_r <= hit;
            cmp_evt_r  <= hit_rise;
            irq_r      <= irq_nxt;
        end
    end

    // read mux; unmapped offsets read zero
    wire logic [31:0] cfg_word  =
        {30'h0000_0000, suppress_r, 1'b0};
    wire logic [31:0] ctrl_word =
        {21'h00_0000, shadow_r, 1'b0, enable_r, 1'b0, in_mode_r};
    wire logic [31:0] st_word   =
        {25'h000_0000, cmp_st_r, 1'b0, cap_st_r};
    wire logic [31:0] mask_word =
        {25'h000_0000, cmp_mask_r, 1'b0, cap_mask_r};

    always_comb begin
        unique case (rd.addr)
            `CCV_OFS_CH0:    rdata = chan_word[0];
            `CCV_OFS_CH1:    rdata = chan_word[1];
            `CCV_OFS_CH2:    rdata = chan_word[2];
            `CCV_OFS_CFG:    rdata = cfg_word;
            `CCV_OFS_CTRL:   rdata = ctrl_word;
            `CCV_OFS_STATUS: rdata = st_word;
            `CCV_OFS_MASK:   rdata = mask_word;
            default:         rdata = `CCV_RST_WORD;
        endcase
    end

    assign compare_evt = cmp_evt_r;
    assign irq         = irq_r;

endmodule : ccv_top

`default_nettype wire

// ==== verif/ccv_top_asserts.sv ====
`default_nettype none

module ccv_top_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [15:0] count,
    input wire logic [2:0]  capture,
    input wire logic        update,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic [2:0]  compare_evt,
    input wire logic        irq
);
    logic seen_r;
    wire  take = hsel && hready && htrans[1];
    // a compare pulse and the irq it raises leave the same edge
    wire  seen = seen_r || (|compare_evt);

    // irq can only follow some earlier event since reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            seen_r <= 1'b0;
        else if ((|capture) || (|compare_evt))
            seen_r <= 1'b1;
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad hresp");
    property p_rd_wait; take && !hwrite |=> !hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("no wait");
    property p_rd_one; !hreadyout |=> hreadyout; endproperty
    a_rd_one: assert property (p_rd_one) else $error("long wait");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("wr wait");
    property p_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("hrdata moved");
    property p_cmp_pulse;
        |compare_evt |=> (compare_evt & $past(compare_evt)) == 3'h0;
    endproperty
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("cmp");
    property p_rst_quiet;
        $rose(hresetn) |-> !irq && compare_evt == 3'h0 && hreadyout;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("rst");
    property p_irq_cause; irq |-> seen; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq");
endmodule : ccv_top_asserts

bind ccv_top ccv_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .count(count),
    .capture(capture), .update(update), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .compare_evt(compare_evt), .irq(irq));

`default_nettype wire

// ==== verif/ccv_top_bench.sv ====
`default_nettype none

module ccv_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ccv_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, update = 0;
    logic        hresp, irq, hreadyout, h;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2, capture = 0, compare_evt;
    logic [15:0] count = 16'hFFFF;
    int          miscompares = 0, n_checks = 0;

    ccv_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .count(count),
        .capture(capture), .update(update), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .compare_evt(compare_evt),
        .irq(irq));

    always #5 hclk = ~hclk;

    task print_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // address phase, then data phase; hready is sampled at each edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do begin @(posedge hclk); n++; end while (!hreadyout && n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (!hreadyout && n < 20);
        q = hrdata;
        if (n >= 20) begin
            miscompares++;
            print_verdict();
        end
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask : rd

    // any compare pulse of one channel within five edges
    task evt(input int i);
        h = 1'b0;
        repeat (5) begin
            @(posedge hclk);
            #1 h = h | compare_evt[i];
        end
    endtask : evt

    task t_reset;
        rd(8'hFC, 32'h0, "cfg reset");
        rd(8'h34, 32'h0, "ch0 reset");
        rd(8'h80, 32'h0, "unmapped");
        wr(8'hFC, 32'h2);
        rd(8'hFC, 32'h2, "cfg set");
        wr(8'hFC, 32'h0);
        rd(8'hFC, 32'h0, "cfg clear");
    endtask : t_reset

    task t_compare;
        wr(8'h58, 32'h10);
        wr(8'h34, 32'h10);
        @(posedge hclk) count <= 16'h0010;
        evt(0);
        chk("cmp0", h, 1'b1);
        chk("irq on", irq, 1'b1);
        rd(8'h54, 32'h10, "status");
        repeat (2) @(posedge hclk);
        #1 chk("irq off", irq, 1'b0);
    endtask : t_compare

    task t_suppress;
        wr(8'hFC, 32'h2);
        wr(8'h34, 32'h10);
        rd(8'h34, 32'h10, "equal write");
        wr(8'h34, 32'h11);
        rd(8'h34, 32'h11, "new write");
        wr(8'hFC, 32'h0);
    endtask : t_suppress

    // compare must wait for the update event to load the shadow copy
    task t_shadow;
        wr(8'h50, 32'h200);
        wr(8'h38, 32'h20);
        @(posedge hclk) count <= 16'h0020;
        evt(1);
        chk("no early cmp", h, 1'b0);
        @(posedge hclk) update <= 1'b1;
        @(posedge hclk) update <= 1'b0;
        evt(1);
        chk("cmp after upd", h, 1'b1);
    endtask : t_shadow

    task t_capture;
        wr(8'h58, 32'h14);
        wr(8'h50, 32'h44);
        @(posedge hclk);
        count   <= 16'h1234;
        capture <= 3'h4;
        @(posedge hclk) capture <= 3'h0;
        #1 chk("cap irq", irq, 1'b1);
        rd(8'h3C, 32'h1234, "captured");
        rd(8'h54, 32'h24, "cap status");
        wr(8'h3C, 32'h5555);
        rd(8'h3C, 32'h1234, "read only");
        wr(8'h50, 32'h4);
        @(posedge hclk);
        count   <= 16'h0999;
        capture <= 3'h4;
        @(posedge hclk) capture <= 3'h0;
        rd(8'h3C, 32'h1234, "disabled");
        #1 chk("no cap irq", irq, 1'b0);
    endtask : t_capture

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_compare();
        t_suppress();
        t_shadow();
        t_capture();
        print_verdict();
    end
endmodule : ccv_top_bench

`default_nettype wire
